// ===== rtl/aacs_pkg.sv
/*
 Shared definitions for the acquisition and conversion sequencer: register
 field positions, reset values, sequencer states, register image structs
 and the decode functions for acquisition length and clock divider.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package aacs_pkg;

  localparam int RES_W = 10;
  localparam int CNT_W = 5;
  localparam int DIV_W = 6;

  // Control register 0 (converter_control_reg) field positions
  localparam int CTL0_ON_BIT = 0;
  localparam int CTL0_GO_BIT = 1;
  localparam int CTL0_CHS_LSB = 2;
  localparam int CTL0_CHS_MSB = 6;

  // Control register 2 (acq_clock_config_reg) field positions
  localparam int CTL2_ADCS_LSB = 0;
  localparam int CTL2_ADCS_MSB = 2;
  localparam int CTL2_ACQT_LSB = 3;
  localparam int CTL2_ACQT_MSB = 5;
  localparam int CTL2_FM_BIT = 7;

  // Reset values
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [2:0] ACQT_MANUAL = 3'h0;
  localparam logic [2:0] ACQT_RST = ACQT_MANUAL;
  localparam logic [2:0] ADCS_RST = 3'h0;
  localparam logic FM_RST = 1'b0;

  // Bit-period counts
  localparam logic [CNT_W-1:0] CONV_LAST = 5'h0a;  // 11 periods: 0..10
  localparam logic [CNT_W-1:0] GAP_LAST = 5'h01;   // 2 periods: 0..1
  localparam logic [1:0] ADCS_FRC = 2'h3;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_SAMPLE,
    ST_DEFER,
    ST_ACQ,
    ST_CONV,
    ST_GAP
  } aacs_state_e;

  typedef struct packed {
    logic [4:0] channel_sel;
    logic go;
    logic converter_on;
  } aacs_ctl0_s;

  typedef struct packed {
    logic result_justify;
    logic [2:0] acq_time_sel;
    logic [2:0] conv_clock_sel;
  } aacs_ctl2_s;

  // Acquisition length in bit periods for each selection code
  function automatic logic [CNT_W-1:0] acq_tads(input logic [2:0] code);
    logic [CNT_W-1:0] n;
    n = 5'h00;
    unique case (code)
      3'h0: n = 5'h00;
      3'h1: n = 5'h02;
      3'h2: n = 5'h04;
      3'h3: n = 5'h06;
      3'h4: n = 5'h08;
      3'h5: n = 5'h0c;
      3'h6: n = 5'h10;
      3'h7: n = 5'h14;
    endcase
    return n;
  endfunction : acq_tads

  // Terminal count of the system clock divider (ratio minus one)
  function automatic logic [DIV_W-1:0] div_last(input logic [2:0] sel);
    logic [DIV_W-1:0] l;
    l = 6'h01;
    unique case (sel)
      3'h0: l = 6'h01;
      3'h4: l = 6'h03;
      3'h1: l = 6'h07;
      3'h5: l = 6'h0f;
      3'h2: l = 6'h1f;
      3'h6: l = 6'h3f;
      3'h3, 3'h7: l = 6'h01;
    endcase
    return l;
  endfunction : div_last

endpackage : aacs_pkg

// ===== rtl/aacs_timebase.sv
/*
 Bit-period timebase: divides the system clock by the selected ratio, or
 follows rising edges of the RC oscillator after synchronising them.
 Assumes frc_osc is asynchronous to clk and rst_n is already synchronised.
*/
`timescale 1ns/1ns
module aacs_timebase
  import aacs_pkg::*;
(
  input wire logic clk,                   // System clock
  input wire logic rst_n,                 // Synchronised reset, active low
  input wire logic [2:0] conv_clock_sel,  // Clock source / divider code
  input wire logic restart,               // Realign divider phase
  input wire logic frc_osc,               // RC oscillator, asynchronous
  output logic tad_tick                   // One pulse per bit period
);

  logic frc_s1;
  logic frc_s2;
  logic frc_s3;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic is_frc;
  logic div_end;

  always_comb begin
    is_frc = (conv_clock_sel[1:0] == ADCS_FRC);  // R6
    div_end = (div_cnt >= div_last(conv_clock_sel));  // R6
    if (restart || div_end) begin  // R23
      next_div_cnt = '0;
    end else begin
      next_div_cnt = div_cnt + 6'h01;
    end
    tad_tick = is_frc ? (frc_s2 & ~frc_s3) : (div_end & ~restart);  // R23
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frc_s1 <= 1'b0;
      frc_s2 <= 1'b0;
      frc_s3 <= 1'b0;
      div_cnt <= '0;
    end else begin
      frc_s1 <= frc_osc;
      frc_s2 <= frc_s1;
      frc_s3 <= frc_s2;
      div_cnt <= next_div_cnt;
    end
  end

endmodule : aacs_timebase

// ===== rtl/aacs_sequencer.sv
/*
 Acquisition and conversion sequencer for a 10-bit successive
 approximation converter: control registers, acquisition timing, the
 11-period conversion, result formatting, done flag and interrupt lines.
 Assumes the analog side follows sample_connect/discharge/dac_code and
 returns its comparator decision on cmp_in; instr_done is a one-cycle
 pulse from the core on clk at the end of each instruction.
*/
// What this block does
// R1 - Nonzero acquisition code samples for 2..20 bit periods, then converts.
// R2 - Code 000 is manual: start converts at once; it is the reset value.
// R3 - Software waits the acquisition interval before starting in manual mode.
// R4 - On completion clear start, set done, resume sampling selected channel.
// R5 - No status shows when programmed acquisition ends.
// R6 - Clock select maps to divide by 2..64 or the RC oscillator.
// R7 - A full conversion lasts 11 bit periods.
// R8 - Done flag sets on every completion regardless of interrupt enable.
// R9 - Only software or reset clears the done flag.
// R10 - Enabled completion raises interrupt at chosen priority and wakes.
// R11 - Justify bit selects left or right alignment of the result.
// R12 - Converter runs only while enabled; start honours acquisition code.
// R13 - Conversion start waits until the next instruction completes.
// R14 - Software should not set start in the enabling write.
// R15 - Code 010 gives exactly four bit periods of acquisition.
// R16 - Completion writes the result into the high and low pair.
// R17 - Clearing start aborts and keeps the previous result.
// R18 - Reset restores registers, turns off, ends any conversion.
// R19 - Two bit periods pass before the channel is reconnected.
// R20 - Capacitor array is discharged after every sample.
// R21 - Above 1 MHz, choose the RC clock only for sleep conversions.
// R22 - Channel select sits in bits 6..2 of control register 0.
// R23 - Bit period comes from a divider or synchronised RC edges.
`timescale 1ns/1ns
module aacs_sequencer
  import aacs_pkg::*;
(
  input wire logic clk,                  // System clock, 100 MHz
  input wire logic rst_b,                // Asynchronous reset, active low
  input wire logic ctl0_wr,              // Write strobe, control reg 0
  input wire logic [7:0] ctl0_wdata,     // Write data, control reg 0
  input wire logic ctl2_wr,              // Write strobe, control reg 2
  input wire logic [7:0] ctl2_wdata,     // Write data, control reg 2
  input wire logic done_clr,             // Clear done flag, pulse
  input wire logic conv_irq_en,          // Interrupt enable
  input wire logic conv_irq_prio,        // 1 = high priority
  input wire logic sleep_mode,           // Core is asleep
  input wire logic instr_done,           // End of instruction, pulse
  input wire logic frc_osc,              // RC oscillator pin
  input wire logic cmp_in,               // Comparator: input >= dac_code
  output logic [7:0] ctl0_rdata,         // Control reg 0 readback
  output logic [7:0] ctl2_rdata,         // Control reg 2 readback
  output logic [7:0] result_hi,          // Result high byte
  output logic [7:0] result_lo,          // Result low byte
  output logic conv_done_flag,           // Sticky completion flag
  output logic irq_hi,                   // High-priority interrupt
  output logic irq_lo,                   // Low-priority interrupt
  output logic wake,                     // Wake request from sleep
  output logic [4:0] channel_sel,        // Channel to sample-and-hold
  output logic sample_connect,           // Channel tied to hold cap
  output logic discharge,                // Capacitor array discharge
  output logic [RES_W-1:0] dac_code      // Trial code to the array
);

  logic rst_s1;
  logic rst_n;
  logic tad_tick;
  logic restart;

  aacs_state_e state;
  aacs_state_e next_state;
  aacs_ctl0_s ctl0;
  aacs_ctl0_s next_ctl0;
  aacs_ctl2_s ctl2;
  aacs_ctl2_s next_ctl2;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [RES_W-1:0] sar;
  logic [RES_W-1:0] next_sar;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] final_code;
  logic [7:0] next_result_hi;
  logic [7:0] next_result_lo;
  logic next_conv_done_flag;
  logic [CNT_W-1:0] acq_last;
  logic go_write_clr;
  logic [RES_W-1:0] next_trial;
  logic [RES_W-1:0] next_dac_code;
  logic next_sample_connect;
  logic next_discharge;

  // One-hot trial bit for conversion period n; period 0 resolves nothing
  function automatic logic [RES_W-1:0] trial_of(input logic [CNT_W-1:0] n);
    logic [RES_W-1:0] t;
    t = '0;
    if (n != '0) begin
      t = RES_W'(10'h200 >> (n - 5'h01));
    end
    return t;
  endfunction : trial_of

  // Result pair image, right or left aligned
  function automatic logic [15:0] justify(input logic [RES_W-1:0] code,
                                         input logic right);
    logic [15:0] r;
    if (right) begin
      r = {6'h00, code};
    end else begin
      r = {code, 6'h00};
    end
    return r;
  endfunction : justify

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  aacs_timebase u_timebase (
    .clk(clk),
    .rst_n(rst_n),
    .conv_clock_sel(ctl2.conv_clock_sel),
    .restart(restart),
    .frc_osc(frc_osc),
    .tad_tick(tad_tick)
  );

  always_comb begin
    next_state = state;
    next_ctl0 = ctl0;
    next_ctl2 = ctl2;
    next_cnt = cnt;
    next_sar = sar;
    next_result_hi = result_hi;
    next_result_lo = result_lo;
    next_conv_done_flag = conv_done_flag;
    acq_last = acq_tads(ctl2.acq_time_sel) - 5'h01;
    go_write_clr = ctl0_wr && !ctl0_wdata[CTL0_GO_BIT];
    trial = (state == ST_CONV) ? trial_of(cnt) : '0;
    // The comparator settles within a clock of dac_code and is read
    // directly: a bit period may be only two clocks long
    final_code = sar | (cmp_in ? trial : '0);

    if (ctl2_wr) begin
      next_ctl2.conv_clock_sel = ctl2_wdata[CTL2_ADCS_MSB:CTL2_ADCS_LSB];
      next_ctl2.acq_time_sel = ctl2_wdata[CTL2_ACQT_MSB:CTL2_ACQT_LSB];
      next_ctl2.result_justify = ctl2_wdata[CTL2_FM_BIT];
    end
    // Start is refused unless the converter was already on
    if (ctl0_wr) begin
      next_ctl0.channel_sel = ctl0_wdata[CTL0_CHS_MSB:CTL0_CHS_LSB];  // R22
      next_ctl0.converter_on = ctl0_wdata[CTL0_ON_BIT];
      if (go_write_clr) begin
        next_ctl0.go = 1'b0;
      end else if (ctl0.converter_on && ctl0_wdata[CTL0_ON_BIT]) begin
        next_ctl0.go = 1'b1;  // R12 R14
      end
    end
    if (done_clr) begin
      next_conv_done_flag = 1'b0;  // R9
    end

    unique case (state)
      ST_OFF: begin
        if (ctl0.converter_on) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (ctl0.go) begin
          next_state = ST_DEFER;
        end
      end
      // Waiting out the next instruction lets sleep be entered first
      ST_DEFER: begin
        if (go_write_clr) begin
          next_state = ST_GAP;
          next_cnt = '0;
        end else if (instr_done) begin  // R13
          next_cnt = '0;
          next_sar = '0;  // R20
          if (ctl2.acq_time_sel == ACQT_MANUAL) begin
            next_state = ST_CONV;  // R2
          end else begin
            next_state = ST_ACQ;  // R1 R15
          end
        end
      end
      // No status shows when acquisition hands over to conversion
      ST_ACQ: begin
        if (go_write_clr) begin
          next_state = ST_GAP;
          next_cnt = '0;
        end else if (tad_tick) begin
          if (cnt == acq_last) begin  // R1 R15 R5
            next_state = ST_CONV;
            next_cnt = '0;
            next_sar = '0;  // R20
          end else begin
            next_cnt = cnt + 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (go_write_clr) begin
          next_state = ST_GAP;  // R17
          next_cnt = '0;
        end else if (tad_tick) begin
          // Period 0 discharges the array; periods 1..10 resolve bits 9..0
          if (cnt == '0) begin
            next_sar = '0;  // R20
          end else begin
            next_sar = final_code;
          end
          if (cnt == CONV_LAST) begin  // R7
            next_state = ST_GAP;
            next_cnt = '0;
            next_ctl0.go = 1'b0;  // R4
            next_conv_done_flag = 1'b1;  // R8 R4
            {next_result_hi, next_result_lo} =
                justify(final_code, ctl2.result_justify);  // R11 R16
          end else begin
            next_cnt = cnt + 5'h01;
          end
        end
      end
      // Two idle periods before the channel is reconnected
      ST_GAP: begin
        if (tad_tick) begin
          if (cnt == GAP_LAST) begin
            next_state = ST_SAMPLE;  // R19 R4
            next_cnt = '0;
          end else begin
            next_cnt = cnt + 5'h01;
          end
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase

    // Switching off ends any conversion; the result pair is untouched
    if (!ctl0.converter_on) begin
      next_state = ST_OFF;  // R12
      next_ctl0.go = 1'b0;
      next_cnt = '0;
    end

    next_trial = (next_state == ST_CONV) ? trial_of(next_cnt) : '0;
    next_dac_code = next_sar | next_trial;
    next_sample_connect = (next_state == ST_SAMPLE) ||
                          (next_state == ST_DEFER) || (next_state == ST_ACQ);
    next_discharge = (next_state == ST_CONV) && (next_cnt == '0);  // R20
  end

  // Outputs to the analog side come from flops so they never glitch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin  // R18
      state <= ST_OFF;
      ctl0 <= '{channel_sel: CHAN_RST, go: 1'b0, converter_on: 1'b0};
      ctl2 <= '{result_justify: FM_RST, acq_time_sel: ACQT_RST,
                conv_clock_sel: ADCS_RST};  // R2
      cnt <= '0;
      sar <= '0;
      result_hi <= 8'h00;
      result_lo <= 8'h00;
      conv_done_flag <= 1'b0;
      dac_code <= '0;
      sample_connect <= 1'b0;
      discharge <= 1'b0;
    end else begin
      state <= next_state;
      ctl0 <= next_ctl0;
      ctl2 <= next_ctl2;
      cnt <= next_cnt;
      sar <= next_sar;
      result_hi <= next_result_hi;
      result_lo <= next_result_lo;
      conv_done_flag <= next_conv_done_flag;
      dac_code <= next_dac_code;
      sample_connect <= next_sample_connect;
      discharge <= next_discharge;
    end
  end

  // The divider sits at phase zero while idle and on an abort, so every
  // timed state opens with a whole bit period; changes made on a tick
  // already meet a wrapped divider. Built without tad_tick, which
  // depends on it.
  assign restart = (state == ST_OFF) || (state == ST_SAMPLE) ||
                   (state == ST_DEFER) || go_write_clr;

  assign ctl0_rdata = {1'b0, ctl0};
  assign ctl2_rdata = {ctl2.result_justify, 1'b0, ctl2.acq_time_sel,
                       ctl2.conv_clock_sel};
  assign irq_hi = conv_done_flag & conv_irq_en & conv_irq_prio;  // R10
  assign irq_lo = conv_done_flag & conv_irq_en & ~conv_irq_prio;  // R10
  assign wake = conv_done_flag & conv_irq_en & sleep_mode;  // R10
  assign channel_sel = ctl0.channel_sel;

endmodule : aacs_sequencer

// ===== tb/aacs_sequencer_assertions.sv
/*
 Timing checks on the sequencer ports.
 Bound into aacs_sequencer; clk and rst_b are the design's own.
*/
`timescale 1ns/1ns
module aacs_sequencer_checker
  import aacs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic done_clr, // Flag clear
  input wire logic conv_irq_en, // Interrupt enable
  input wire logic conv_irq_prio, // Priority
  input wire logic sleep_mode, // Core asleep
  input wire logic instr_done, // Instruction end
  input wire logic [7:0] ctl0_rdata, // Control 0
  input wire logic [7:0] ctl2_rdata, // Control 2
  input wire logic [7:0] result_hi, // Result high
  input wire logic [7:0] result_lo, // Result low
  input wire logic conv_done_flag, // Done flag
  input wire logic irq_hi, // High interrupt
  input wire logic irq_lo, // Low interrupt
  input wire logic wake, // Wake request
  input wire logic sample_connect, // Tracking
  input wire logic discharge // Array discharge
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_irq_route: assert property (
    irq_hi == (conv_done_flag && conv_irq_en && conv_irq_prio) &&
    irq_lo == (conv_done_flag && conv_irq_en && !conv_irq_prio))
    else $error("interrupt lines disagree with flag");
  a_wake_sleep: assert property (
    wake == (conv_done_flag && conv_irq_en && sleep_mode))
    else $error("wake disagrees with flag");
  a_flag_sticky: assert property (
    conv_done_flag && !done_clr |=> conv_done_flag)
    else $error("done flag dropped by itself");
  a_done_clears_go: assert property (
    $rose(conv_done_flag) |-> !ctl0_rdata[1])
    else $error("start bit still set at completion");
  a_gap_wait: assert property (
    $rose(conv_done_flag) && ctl2_rdata[2:0] == 3'h0
    |-> !sample_connect [*4] ##1 sample_connect)
    else $error("gap before sampling is wrong");
  a_off_idle: assert property (
    !ctl0_rdata[0] [*2] |-> !sample_connect && !discharge && !ctl0_rdata[1])
    else $error("activity while converter off");
  a_manual_start: assert property (
    ctl0_rdata[1] && $past(ctl0_rdata[1]) && sample_connect && instr_done
    && ctl2_rdata[5:3] == 3'h0 |=> discharge)
    else $error("manual start did not convert");
  a_acq_four: assert property (
    ctl0_rdata[1] && $past(ctl0_rdata[1]) && sample_connect && instr_done
    && ctl2_rdata[5:0] == 6'h10 |=> sample_connect [*8] ##1 discharge)
    else $error("acquisition length wrong");
  a_conv_len: assert property (
    $rose(discharge) && ctl2_rdata[2:0] == 3'h0 |-> ##1 discharge
    ##1 !discharge ##19 ctl0_rdata[1] ##1 !ctl0_rdata[1])
    else $error("conversion length wrong");
  a_result_hold: assert property (
    $changed(result_hi) || $changed(result_lo)
    |-> $fell(ctl0_rdata[1]) && conv_done_flag)
    else $error("result changed outside completion");
endmodule : aacs_sequencer_checker

// ===== tb/aacs_analog_model.sv
/*
 Behavioural sample-and-hold and comparator.
 Tracks vin while sample_connect is high, holds it otherwise.
*/
`timescale 1ns/1ns
module aacs_analog_model
  import aacs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic sample_connect, // Channel on hold cap
  input wire logic [RES_W-1:0] dac_code, // Trial code
  input wire logic [RES_W-1:0] vin, // Selected channel level
  output logic cmp_in // Comparator decision
);
  logic [RES_W-1:0] held = 10'h000;
  logic tog = 1'b0;
  always_ff @(posedge clk) begin
    tog <= ~tog;
    if (sample_connect) held <= vin;
  end
  // Meaningless while tracking, so keep it moving
  assign cmp_in = sample_connect ? tog : (held >= dac_code);
endmodule : aacs_analog_model

// ===== tb/aacs_sequencer_test.sv
/*
 Self-checking bench for aacs_sequencer.
 Needs aacs_analog_model and the checker.
*/
`timescale 1ns/1ns
module aacs_sequencer_test;
  import aacs_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, ctl0_wr = 1'b0, ctl2_wr = 1'b0;
  logic done_clr = 1'b0, conv_irq_en = 1'b0, conv_irq_prio = 1'b0;
  logic sleep_mode = 1'b0, instr_done = 1'b0, frc_osc = 1'b0, cmp_in;
  logic [7:0] ctl0_wdata = 8'h00, ctl2_wdata = 8'h00;
  logic [7:0] ctl0_rdata, ctl2_rdata, result_hi, result_lo;
  logic conv_done_flag, irq_hi, irq_lo, wake, sample_connect, discharge;
  logic [4:0] channel_sel, ch;
  logic [RES_W-1:0] dac_code, vin = 10'h000;
  logic [15:0] exp_q[$];
  logic [15:0] pend, last = 16'h0000;
  logic prev_flag = 1'b0;
  int mismatches = 0, checked = 0, dcnt = 0, ratio = 0;

  always #5 clk = ~clk;
  always #87 frc_osc = ~frc_osc;

  aacs_sequencer uut (.clk, .rst_b, .ctl0_wr, .ctl0_wdata, .ctl2_wr,
    .ctl2_wdata, .done_clr, .conv_irq_en, .conv_irq_prio, .sleep_mode,
    .instr_done, .frc_osc, .cmp_in, .ctl0_rdata, .ctl2_rdata, .result_hi,
    .result_lo, .conv_done_flag, .irq_hi, .irq_lo, .wake, .channel_sel,
    .sample_connect, .discharge, .dac_code);
  aacs_analog_model far (.clk, .sample_connect, .dac_code, .vin, .cmp_in);

  task automatic check(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic w0(input logic [7:0] d);
    ctl0_wdata <= d;
    ctl0_wr <= 1'b1;
    @(posedge clk);
    ctl0_wr <= 1'b0;
    @(posedge clk);
  endtask : w0

  task automatic w2(input logic [7:0] d);
    ctl2_wdata <= d;
    ctl2_wr <= 1'b1;
    @(posedge clk);
    ctl2_wr <= 1'b0;
    @(posedge clk);
  endtask : w2

  task automatic start(input logic [2:0] sel, acq, input logic j);
    logic [9:0] v;
    v = 10'($urandom);
    ch = 5'($urandom);
    vin <= v;
    pend = j ? {6'h00, v} : {v, 6'h00};
    ratio = (sel[1:0] == 2'h3) ? 0 : 2 << (sel[1:0] * 2 + sel[2]);
    w2({j, 1'b0, acq, sel});
    w0({1'b0, ch, 2'b01});
    tick(2);
    w0({1'b0, ch, 2'b11});
    check(16'(ctl0_rdata), 16'({1'b0, ch, 2'b11}));
    check(16'(channel_sel), 16'(ch));
    @(posedge clk);
    check(16'(discharge), 16'h0);
    check(16'(sample_connect), 16'h1);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
  endtask : start

  task automatic back;
    repeat (400) if (sample_connect !== 1'b1) @(posedge clk);
    check(16'(sample_connect), 16'h1);
  endtask : back

  task automatic finish;
    exp_q.push_back(pend);
    repeat (3000) begin
      @(posedge clk);
      if (conv_done_flag === 1'b1) break;
    end
    check(16'(conv_done_flag), 16'h1);
    last = pend;
    tick(3);
    check(16'(conv_done_flag), 16'h1);
    done_clr <= 1'b1;
    @(posedge clk);
    done_clr <= 1'b0;
    tick(2);
    check(16'(conv_done_flag), 16'h0);
    back();
  endtask : finish

  // Result at each completion, bit-period length at each discharge when the divider sets the clock
  always @(posedge clk) begin
    if (conv_done_flag === 1'b1 && !prev_flag)
      check({result_hi, result_lo}, exp_q.pop_front());
    prev_flag = conv_done_flag;
    if (discharge === 1'b1) dcnt++;
    else if (dcnt != 0) begin
      if (ratio != 0) check(16'(dcnt), 16'(ratio));
      dcnt = 0;
    end
  end

  initial begin
    void'($urandom(58));
    tick(8);
    rst_b <= 1'b1;
    tick(3);
    check({ctl0_rdata, ctl2_rdata}, 16'h0000);
    w0(8'h03);
    check(16'(ctl0_rdata), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      conv_irq_en <= 1'($urandom);
      conv_irq_prio <= 1'($urandom);
      sleep_mode <= (i[1:0] == 2'h3) ? 1'b1 : 1'($urandom);
      start(3'(i), 3'(7 - i), i[0]);
      finish();
    end
    start(3'h0, 3'h2, 1'b1);
    finish();
    start(3'h0, 3'h0, 1'b0);
    finish();
    // Abort by clearing start mid-conversion
    start(3'h1, 3'h0, 1'b1);
    tick(20);
    w0({1'b0, ch, 2'b01});
    tick(6);
    check(16'(sample_connect), 16'h0);
    back();
    check({result_hi, result_lo}, last);
    check(16'(conv_done_flag), 16'h0);
    // Switch off mid-conversion
    start(3'h1, 3'h0, 1'b0);
    tick(20);
    w0(8'h00);
    tick(1);
    check(16'({ctl0_rdata, 7'h00, sample_connect}), 16'h0);
    check({result_hi, result_lo}, last);
    // Reset mid-conversion
    start(3'h1, 3'h0, 1'b1);
    tick(20);
    rst_b <= 1'b0;
    tick(2);
    check({result_hi, result_lo}, 16'h0000);
    check({ctl0_rdata, ctl2_rdata}, 16'h0000);
    rst_b <= 1'b1;
    tick(3);
    start(3'h0, 3'h0, 1'b1);
    finish();
    summarize();
  end

  initial begin
    #500000;
    mismatches++;
    summarize();
  end
endmodule : aacs_sequencer_test

bind aacs_sequencer aacs_sequencer_checker chk (.clk, .rst_b, .done_clr,
  .conv_irq_en, .conv_irq_prio, .sleep_mode, .instr_done, .ctl0_rdata,
  .ctl2_rdata, .result_hi, .result_lo, .conv_done_flag, .irq_hi, .irq_lo,
  .wake, .sample_connect, .discharge);
